// *** design/flash_program_protection_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "flash_ctrl_defs.svh"
// Operation
// - High protect register guards blocks 0x4000-0x4fff
// - Low protect register guards eight 2KB blocks
// - Writer enters programming mode via power-on reset
// - Block erase only through in-system path
// - Operation code selects read, program, erase all
// - Program and verify repeatable in programming mode
// - Security and ID not ordinary flash locations
// - Programmed security bit returns to one only through erase-all or reset
// - Only erase-all or reset restores security bits
// - Security register sits at location FFF
// - ID read codes return fixed identification values
// - Lock low blocks external reads of internal
// - Internal table reads always reach both
// - Lock high places no restriction
// - Oscillator bit selects internal or crystal
// - Enable control bits are active low
// - Programming enable arms mode after idle wake
module flash_program_protection_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Special-function-register bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    input wire logic sfr_re_i,
    output logic [7:0] sfr_rdata_o,
    // Mode entry
    input wire logic writer_strap_i,
    input wire logic core_idle_i,
    input wire logic wake_irq_i,
    output logic prog_mode_o,
    // Flash array macro
    output flash_cmd_type flash_cmd_o,
    output logic flash_go_o,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    input wire logic [7:0] flash_rdata_i,
    output logic busy_o,
    // Code-table read guard
    input wire logic tbl_req_i,
    input wire logic tbl_from_internal_i,
    input wire logic tbl_target_internal_i,
    output logic tbl_allow_o,
    // Clock source select
    output logic osc_internal_o
);
    // Is the addressed block guarded by a protection bit
    function automatic logic block_guarded(input logic [14:0] a, input logic [7:0] lo, input logic [7:0] hi);
        logic [3:0] blk;
        blk = a[14:11];
        if (blk < `HIGH_BLOCK_BASE) begin
            block_guarded = lo[blk[2:0]];
        end else if (blk < `HIGH_BLOCK_BASE + 4'd2) begin
            block_guarded = hi[blk[0]];
        end else begin
            block_guarded = 1'b0;
        end
    endfunction : block_guarded

    // Does this operation change cell contents
    function automatic logic op_alters(input logic [3:0] op);
        op_alters = (op == `OP_PROGRAM) || (op == `OP_ERASE_APP) || (op == `OP_ERASE_ALL) ||
                    (op == `OP_ERASE_BLOCK) || (op == `OP_PROG_MAP) || (op == `OP_ERASE_MAP) ||
                    (op == `OP_CHECK);
    endfunction : op_alters

    // Registers seen by software
    logic [7:0] addr_low, next_addr_low; // Flash address low byte
    logic [7:0] addr_high, next_addr_high; // Flash address high byte
    logic [7:0] data_reg, next_data_reg; // Flash data
    logic [7:0] control, next_control; // Enables and operation code
    logic prog_en, next_prog_en; // Programming enable
    logic [7:0] hi_prot, next_hi_prot; // High block guards
    logic [7:0] lo_prot, next_lo_prot; // Low block guards
    logic [7:0] security, next_security; // Security option bits
    // Mode and sequencer
    logic writer_mode, next_writer_mode; // Entered through reset strap
    logic isp_mode, next_isp_mode; // Entered through idle wake
    logic strap_done, next_strap_done; // Strap caught once
    seq_state_type state, next_state;
    // Registered outputs
    logic [7:0] rdata, next_rdata;
    flash_cmd_type cmd, next_cmd;
    logic go, next_go;
    logic allow, next_allow;
    logic busy, next_busy; // Sequencer running
    logic prog_mode, next_prog_mode; // Writer or in-system mode
    // Strap synchroniser, three stages
    logic [2:0] strap_sync;
    // Ones walk in after reset; the strap is trusted only once the chain holds real samples
    logic [2:0] strap_fill;

    logic [14:0] full_addr; // Combined flash address
    logic [3:0] opcode; // Operation code field
    assign full_addr = {addr_high[6:0], addr_low};
    assign opcode = control[3:0];

    // Strap passes three flops; only stages two and three are compared
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_sync <= 3'b000;
            strap_fill <= 3'b000;
        end else begin
            strap_sync <= {strap_sync[1:0], writer_strap_i};
            strap_fill <= {strap_fill[1:0], 1'b1};
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        next_addr_low = addr_low;
        next_addr_high = addr_high;
        next_data_reg = data_reg;
        next_control = control;
        next_prog_en = prog_en;
        next_hi_prot = hi_prot;
        next_lo_prot = lo_prot;
        next_security = security;
        next_writer_mode = writer_mode;
        next_isp_mode = isp_mode;
        next_strap_done = strap_done;
        next_state = state;
        next_rdata = 8'h00;
        next_cmd = cmd;
        next_go = 1'b0;
        next_allow = allow;
        // Strap is sampled once, after it settles past reset release
        // Without the fill check the reset zeros would agree at once and hide the strap
        if (!strap_done && strap_fill[2] && (strap_sync[1] == strap_sync[2])) begin
            next_strap_done = 1'b1;
            next_writer_mode = strap_sync[2];
        end
        // Idle plus wake switches into in-system programming
        if (prog_en && core_idle_i && wake_irq_i) begin
            next_isp_mode = 1'b1;
        end else if (!prog_en) begin
            next_isp_mode = 1'b0;
        end
        // Register reads; unmapped addresses read zero
        if (sfr_re_i) begin
            case (sfr_addr_i)
                `ADDR_FLASH_ADDR_LOW: next_rdata = addr_low;
                `ADDR_FLASH_ADDR_HIGH: next_rdata = addr_high;
                `ADDR_FLASH_DATA: next_rdata = data_reg;
                `ADDR_FLASH_CONTROL: next_rdata = {2'b00, control[5:0]};
                `ADDR_PROG_CONTROL: next_rdata = {7'h00, prog_en};
                `ADDR_HIGH_BLOCK_PROTECT: next_rdata = {6'h00, hi_prot[1:0]};
                `ADDR_LOW_BLOCK_PROTECT: next_rdata = lo_prot;
                default: next_rdata = 8'h00;
            endcase
        end
        // Register writes
        if (sfr_we_i) begin
            case (sfr_addr_i)
                `ADDR_FLASH_ADDR_LOW: next_addr_low = sfr_wdata_i;
                `ADDR_FLASH_ADDR_HIGH: next_addr_high = sfr_wdata_i;
                `ADDR_FLASH_DATA: next_data_reg = sfr_wdata_i;
                `ADDR_FLASH_CONTROL: next_control = {2'b00, sfr_wdata_i[5:0]};
                `ADDR_PROG_CONTROL: next_prog_en = sfr_wdata_i[0];
                `ADDR_HIGH_BLOCK_PROTECT: next_hi_prot = {6'h00, sfr_wdata_i[1:0]};
                `ADDR_LOW_BLOCK_PROTECT: next_lo_prot = sfr_wdata_i;
                default: ;
            endcase
        end
        // Sequencer: a control write with chip enable low starts one operation
        case (state)
            ST_IDLE: begin
                if (sfr_we_i && (sfr_addr_i == `ADDR_FLASH_CONTROL) && !sfr_wdata_i[`FC_CE_BIT]) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                next_state = ST_CAPTURE;
                next_cmd = '{op: opcode, addr: full_addr, wdata: data_reg};
                // Out of programming mode flash is read-only
                if (op_alters(opcode) && !(writer_mode || isp_mode)) begin
                    next_go = 1'b0;
                end else if (opcode == `OP_ERASE_BLOCK && !isp_mode) begin
                    next_go = 1'b0;
                end else if ((opcode == `OP_PROGRAM || opcode == `OP_ERASE_BLOCK) &&
                             block_guarded(full_addr, lo_prot, hi_prot)) begin
                    next_go = 1'b0;
                end else if (opcode == `OP_PROG_MAP && full_addr[11:0] == `SECURITY_LOC) begin
                    next_security = security & data_reg;
                end else if (opcode == `OP_ERASE_ALL) begin
                    next_security = `RST_SECURITY;
                    next_go = 1'b1;
                end else if (opcode == `OP_MAKER_ID || opcode == `OP_PART_ID ||
                             opcode == `OP_READ_MAP) begin
                    next_go = 1'b0; // special space reads never reach the array
                end else begin
                    next_go = 1'b1;
                end
            end
            ST_CAPTURE: begin
                next_state = ST_IDLE;
                // Data returns only when output enable is low
                if (!control[`FC_OE_BIT]) begin
                    case (opcode)
                        `OP_MAKER_ID: next_data_reg = MAKER_ID;
                        `OP_PART_ID: next_data_reg = PART_ID;
                        `OP_READ_MAP: next_data_reg = security;
                        `OP_READ, `OP_PROG_VFY, `OP_ERASE_VFY: next_data_reg = flash_rdata_i;
                        default: ;
                    endcase
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Registered status so the outputs come straight from flops
        next_busy = (next_state != ST_IDLE);
        next_prog_mode = next_writer_mode | next_isp_mode;
        // Code-table read guard
        if (tbl_req_i) begin
            if (tbl_from_internal_i) begin
                next_allow = 1'b1;
            end else if (!security[`SEC_TBL_LOCK_BIT]) begin
                next_allow = !tbl_target_internal_i;
            end else begin
                next_allow = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_low <= 8'h00;
            addr_high <= 8'h00;
            data_reg <= 8'h00;
            control <= `RST_FLASH_CONTROL;
            prog_en <= 1'b0;
            hi_prot <= `RST_PROTECT;
            lo_prot <= `RST_PROTECT;
            security <= `RST_SECURITY;
            writer_mode <= 1'b0;
            isp_mode <= 1'b0;
            strap_done <= 1'b0;
            state <= ST_IDLE;
            rdata <= 8'h00;
            cmd <= '0;
            go <= 1'b0;
            allow <= 1'b1;
            busy <= 1'b0;
            prog_mode <= 1'b0;
        end else begin
            addr_low <= next_addr_low;
            addr_high <= next_addr_high;
            data_reg <= next_data_reg;
            control <= next_control;
            prog_en <= next_prog_en;
            hi_prot <= next_hi_prot;
            lo_prot <= next_lo_prot;
            security <= next_security;
            writer_mode <= next_writer_mode;
            isp_mode <= next_isp_mode;
            strap_done <= next_strap_done;
            state <= next_state;
            rdata <= next_rdata;
            cmd <= next_cmd;
            go <= next_go;
            allow <= next_allow;
            busy <= next_busy;
            prog_mode <= next_prog_mode;
        end
    end

    // Outputs straight from flops
    assign sfr_rdata_o = rdata;
    assign flash_cmd_o = cmd;
    assign flash_go_o = go;
    assign flash_ce_n_o = control[`FC_CE_BIT];
    assign flash_oe_n_o = control[`FC_OE_BIT];
    assign busy_o = busy;
    assign prog_mode_o = prog_mode;
    assign tbl_allow_o = allow;
    assign osc_internal_o = security[`SEC_OSC_SEL_BIT];

    // Checks
    sequence s_guarded_prog;
        state == ST_ISSUE && opcode == `OP_PROGRAM && block_guarded(full_addr, lo_prot, hi_prot);
    endsequence
    property p_guard_blocks;
        @(posedge clk_i) disable iff (!rstn_i) s_guarded_prog |=> !flash_go_o;
    endproperty
    a_guard_blocks: assert property (p_guard_blocks) else $error("guarded block was written");
    property p_sec_no_rise;
        @(posedge clk_i) disable iff (!rstn_i)
            !(state == ST_ISSUE && opcode == `OP_ERASE_ALL) |=> ((security & ~$past(security)) == 8'h00);
    endproperty
    a_sec_no_rise: assert property (p_sec_no_rise) else $error("security bit rose without erase-all");
    property p_erase_all_clears;
        @(posedge clk_i) disable iff (!rstn_i)
            state == ST_ISSUE && opcode == `OP_ERASE_ALL && prog_mode_o |=> security == 8'hFF && flash_go_o;
    endproperty
    a_erase_all_clears: assert property (p_erase_all_clears) else $error("erase-all left security");
    property p_block_erase_isp;
        @(posedge clk_i) disable iff (!rstn_i) state == ST_ISSUE && opcode == `OP_ERASE_BLOCK && !isp_mode |=> !flash_go_o;
    endproperty
    a_block_erase_isp: assert property (p_block_erase_isp) else $error("block erase outside isp");
    property p_readonly;
        @(posedge clk_i) disable iff (!rstn_i) flash_go_o |-> !op_alters(flash_cmd_o.op) || $past(prog_mode_o);
    endproperty
    a_readonly: assert property (p_readonly) else $error("write while read-only");
    property p_lock;
        @(posedge clk_i) disable iff (!rstn_i)
            tbl_req_i && !tbl_from_internal_i && tbl_target_internal_i && !security[0] |=> !tbl_allow_o;
    endproperty
    a_lock: assert property (p_lock) else $error("locked table read allowed");
    property p_internal_free;
        @(posedge clk_i) disable iff (!rstn_i) tbl_req_i && (tbl_from_internal_i || security[0]) |=> tbl_allow_o;
    endproperty
    a_internal_free: assert property (p_internal_free) else $error("table read wrongly blocked");
    property p_id_read;
        @(posedge clk_i) disable iff (!rstn_i)
            state == ST_CAPTURE && opcode == `OP_MAKER_ID && !control[5] |=> data_reg == MAKER_ID;
    endproperty
    a_id_read: assert property (p_id_read) else $error("maker id not returned");
    property p_start;
        @(posedge clk_i) disable iff (!rstn_i)
            state == ST_IDLE && sfr_we_i && sfr_addr_i == `ADDR_FLASH_CONTROL && !sfr_wdata_i[4]
            |=> busy_o ##1 busy_o ##1 !busy_o;
    endproperty
    a_start: assert property (p_start) else $error("operation sequence wrong");
endmodule : flash_program_protection_ctrl
`default_nettype wire

// *** include/flash_ctrl_defs.svh ***
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH
// Special-function-register addresses
`define ADDR_FLASH_ADDR_LOW 8'hC4
`define ADDR_FLASH_ADDR_HIGH 8'hC5
`define ADDR_FLASH_DATA 8'hC6
`define ADDR_FLASH_CONTROL 8'hC7
`define ADDR_PROG_CONTROL 8'hCF
`define ADDR_HIGH_BLOCK_PROTECT 8'hD4
`define ADDR_LOW_BLOCK_PROTECT 8'hD5
// Reset values
`define RST_FLASH_CONTROL 8'h30
`define RST_PROTECT 8'h00
`define RST_SECURITY 8'hFF
// Field positions in the flash control register
`define FC_OE_BIT 5
`define FC_CE_BIT 4
// Security option bit positions
`define SEC_TBL_LOCK_BIT 0
`define SEC_OSC_SEL_BIT 1
// Special setting space location of the security option register
`define SECURITY_LOC 15'h0FFF
// Operation codes
`define OP_READ 4'h0
`define OP_PROGRAM 4'h1
`define OP_ERASE_APP 4'h2
`define OP_READ_MAP 4'h3
`define OP_PROG_MAP 4'h4
`define OP_ERASE_MAP 4'h5
`define OP_ERASE_ALL 4'h6
`define OP_CHECK 4'h8
`define OP_ERASE_VFY 4'h9
`define OP_PROG_VFY 4'hA
`define OP_MAKER_ID 4'hB
`define OP_PART_ID 4'hC
`define OP_ERASE_BLOCK 4'hF
// Block index of the first high block (0x4000)
`define HIGH_BLOCK_BASE 4'h8
`endif

// *** include/flash_ctrl_pkg.sv ***
package flash_ctrl_pkg;
    // Request towards the flash array macro
    typedef struct packed {
        logic [3:0] op;
        logic [14:0] addr;
        logic [7:0] wdata;
    } flash_cmd_type;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_CAPTURE = 3'b100
    } seq_state_type;
endpackage : flash_ctrl_pkg

// *** sim/flash_array_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module flash_array_model
    import flash_ctrl_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Request from the sequencer
    input wire flash_cmd_type cmd_i,
    input wire logic go_i,
    // Data back to the sequencer
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:32767]; // Cell contents
    logic [7:0] noise = 8'h5a; // Shown while no request is live, never the last data
    // Blank when delivered: every cell starts erased
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'hff;
        end
    end
    // Data only valid in the strobe cycle, so a late sample sees garbage
    assign rdata_o = go_i ? mem[cmd_i.addr] : noise;
    // Cell updates; programming can only clear bits
    always @(posedge clk_i) begin
        noise <= ~noise + 8'h01;
        if (go_i) begin
            case (cmd_i.op)
                4'h1: mem[cmd_i.addr] <= mem[cmd_i.addr] & cmd_i.wdata;
                4'h2: for (int i = 0; i < 16384; i++) mem[i] <= 8'hff;
                4'h6: for (int i = 0; i < 32768; i++) mem[i] <= 8'hff;
                4'hf: for (int i = 0; i < 512; i++) mem[{cmd_i.addr[14:9], 9'(i)}] <= 8'hff;
                default: ;
            endcase
        end
    end
endmodule : flash_array_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "flash_ctrl_defs.svh"
module tb_top;
    import flash_ctrl_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] PART = 8'hc3; // Arbitrary value
    // Stimulus and responses
    logic clk, rstn, we, re, strap, idle, wake, treq, tint, ttgt;
    logic [7:0] addr, wdata, rdata, frd;
    logic pmode, go, ce_n, oe_n, busy, allow, osc;
    flash_cmd_type cmd;
    int err_total = 0;
    int tests_run = 0;
    int go_cnt = 0; // Array strobes seen
    // Protection cases: guards {high, low}, target, strobe expected
    logic [15:0] p_reg [6] = '{16'h0001, 16'h0080, 16'h0200, 16'h0200, 16'h0100, 16'h00fe};
    logic [14:0] p_addr [6] = '{15'h0020, 15'h3fff, 15'h4800, 15'h47ff, 15'h4000, 15'h0700};
    logic p_fire [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

    flash_program_protection_ctrl #(.MAKER_ID(MAKER), .PART_ID(PART)) u_dut (
        .clk_i(clk), .rstn_i(rstn),
        .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_we_i(we), .sfr_re_i(re), .sfr_rdata_o(rdata),
        .writer_strap_i(strap), .core_idle_i(idle), .wake_irq_i(wake), .prog_mode_o(pmode),
        .flash_cmd_o(cmd), .flash_go_o(go), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
        .flash_rdata_i(frd), .busy_o(busy),
        .tbl_req_i(treq), .tbl_from_internal_i(tint), .tbl_target_internal_i(ttgt), .tbl_allow_o(allow),
        .osc_internal_o(osc)
    );
    flash_array_model u_mem (.clk_i(clk), .cmd_i(cmd), .go_i(go), .rdata_o(frd));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Strobes counted off the registered pulse, so a stuck strobe counts twice
    always @(posedge clk) begin
        if (go === 1'b1) begin
            go_cnt <= go_cnt + 1;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Register write, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    // Register read; data stands for one cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    // Start an operation; busy falls on the second edge after the write
    task automatic op(input logic [7:0] c, input logic f);
        int g;
        g = go_cnt;
        wr(`ADDR_FLASH_CONTROL, c);
        repeat (3) @(posedge clk);
        #1 chk(8'(busy), 8'h00);
        chk(8'(go_cnt - g), 8'(f));
    endtask : op
    task automatic flash(input logic [14:0] a, input logic [7:0] d, input logic [7:0] c, input logic f);
        wr(`ADDR_FLASH_ADDR_LOW, a[7:0]);
        wr(`ADDR_FLASH_ADDR_HIGH, {1'b0, a[14:8]});
        wr(`ADDR_FLASH_DATA, d);
        op(c, f);
    endtask : flash
    // Read one cell back through the data register
    task automatic peek(input logic [14:0] a, input logic [7:0] exp);
        flash(a, 8'h00, 8'h00, 1'b1);
        rd(`ADDR_FLASH_DATA, exp);
    endtask : peek
    // Table read verdict, one cycle after the request
    task automatic tbl(input logic from_int, input logic to_int, input logic exp);
        @(posedge clk);
        treq <= 1'b1;
        tint <= from_int;
        ttgt <= to_int;
        @(posedge clk);
        treq <= 1'b0;
        #1 chk(8'(allow), 8'(exp));
    endtask : tbl
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        {rstn, we, re, strap, idle, wake, treq, tint, ttgt} = '0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        chk(8'({osc, allow, pmode}), 8'h06);
        rd(`ADDR_HIGH_BLOCK_PROTECT, 8'h00);
        rd(`ADDR_LOW_BLOCK_PROTECT, 8'h00);
        rd(`ADDR_FLASH_CONTROL, 8'h30);
        chk(8'({oe_n, ce_n}), 8'h03);
        $display("test reset done");
        // Reserved high bits read back as zero; unmapped place ignored
        wr(`ADDR_HIGH_BLOCK_PROTECT, 8'hff);
        rd(`ADDR_HIGH_BLOCK_PROTECT, 8'h03);
        wr(`ADDR_LOW_BLOCK_PROTECT, 8'ha5);
        rd(`ADDR_LOW_BLOCK_PROTECT, 8'ha5);
        wr(8'h01, 8'h55);
        rd(8'h01, 8'h00);
        wr(`ADDR_HIGH_BLOCK_PROTECT, 8'h00);
        wr(`ADDR_LOW_BLOCK_PROTECT, 8'h00);
        $display("test registers done");
        // Altering codes run with output enable off (bit5 high) and chip enable on (bit4 low)
        flash(15'h0010, 8'h3c, 8'h21, 1'b0);
        peek(15'h0010, 8'hff);
        chk(8'({oe_n, ce_n}), 8'h00);
        op(8'h30, 1'b0);
        chk(8'({oe_n, ce_n}), 8'h03);
        $display("test read only done");
        // In-system mode: enable, then idle and a wake interrupt together
        wr(`ADDR_PROG_CONTROL, 8'h01);
        @(posedge clk);
        idle <= 1'b1;
        wake <= 1'b1;
        @(posedge clk);
        idle <= 1'b0;
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(8'(pmode), 8'h01);
        flash(15'h0010, 8'h3c, 8'h21, 1'b1);
        peek(15'h0010, 8'h3c);
        flash(15'h0010, 8'h0f, 8'h21, 1'b1);
        peek(15'h0010, 8'h0c);
        flash(15'h0010, 8'h00, 8'h0a, 1'b1);
        rd(`ADDR_FLASH_DATA, 8'h0c);
        $display("test program done");
        // Guarded blocks refuse program and block erase
        for (int i = 0; i < 6; i++) begin
            wr(`ADDR_HIGH_BLOCK_PROTECT, p_reg[i][15:8]);
            wr(`ADDR_LOW_BLOCK_PROTECT, p_reg[i][7:0]);
            flash(p_addr[i], 8'h00, 8'h21, p_fire[i]);
        end
        wr(`ADDR_LOW_BLOCK_PROTECT, 8'h01);
        flash(15'h0010, 8'h00, 8'h2f, 1'b0);
        peek(15'h0010, 8'h0c);
        wr(`ADDR_LOW_BLOCK_PROTECT, 8'h00);
        flash(15'h0010, 8'h00, 8'h2f, 1'b1);
        peek(15'h0010, 8'hff);
        flash(15'h0010, 8'h00, 8'h09, 1'b1);
        rd(`ADDR_FLASH_DATA, 8'hff);
        $display("test protection done");
        // Security bits clear one way; only erase-all or reset restores them
        flash(15'h0fff, 8'hfc, 8'h24, 1'b0);
        chk(8'(osc), 8'h00);
        flash(15'h0fff, 8'hff, 8'h24, 1'b0);
        flash(15'h0fff, 8'h00, 8'h03, 1'b0);
        rd(`ADDR_FLASH_DATA, 8'hfc);
        tbl(1'b0, 1'b1, 1'b0);
        tbl(1'b0, 1'b0, 1'b1);
        tbl(1'b1, 1'b1, 1'b1);
        op(8'h0b, 1'b0);
        rd(`ADDR_FLASH_DATA, MAKER);
        op(8'h0c, 1'b0);
        rd(`ADDR_FLASH_DATA, PART);
        op(8'h26, 1'b1);
        chk(8'(osc), 8'h01);
        flash(15'h0fff, 8'h00, 8'h03, 1'b0);
        rd(`ADDR_FLASH_DATA, 8'hff);
        tbl(1'b0, 1'b1, 1'b1);
        $display("test security done");
        // Writer entry by power-on reset; block erase refused there
        @(posedge clk);
        rstn <= 1'b0;
        strap <= 1'b1;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk(8'(pmode), 8'h01);
        flash(15'h0010, 8'h00, 8'h2f, 1'b0);
        flash(15'h0010, 8'h81, 8'h21, 1'b1);
        peek(15'h0010, 8'h81);
        $display("test writer done");
        summarize();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (6000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
